// [src/flp_pkg.sv]
/*
 * Package for the flash lock and sector protect block: key and command
 * codes, geometry of the flash array, reset values and field sizes.
 * Assumes a byte-wide register write port from the CPU side.
 */
package flp_pkg;

    // Flash geometry: 1 KB array, 512-byte pages gives 2 pages
    localparam int FLP_ADDR_W = 10;
    localparam int FLP_PAGE_W = 1;
    localparam int FLP_PAGE_BITS = FLP_ADDR_W - FLP_PAGE_W;
    localparam int FLP_SECTORS = 8;
    localparam int FLP_SECT_ADDR_W = 3;
    // Sector is one eighth of flash, never smaller than a page
    localparam int FLP_SECT_SHIFT_RAW = FLP_ADDR_W - FLP_SECT_ADDR_W;
    localparam int FLP_SECT_SHIFT = (FLP_SECT_SHIFT_RAW < FLP_PAGE_BITS) ?
                                    FLP_PAGE_BITS : FLP_SECT_SHIFT_RAW;

    // Flash control codes
    localparam logic [7:0] FLP_KEY1 = 8'h73;
    localparam logic [7:0] FLP_KEY2 = 8'h8C;
    localparam logic [7:0] FLP_CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] FLP_CMD_SECT_SEL = 8'h5E;

    // Reset values
    localparam logic [7:0] FLP_SECT_PROT_RST = 8'h00;
    localparam logic [7:0] FLP_PAGE_SEL_RST = 8'h00;

    typedef enum logic [2:0] {
        FLP_LOCKED,
        FLP_KEY1_SEEN,
        FLP_KEY2_SEEN,
        FLP_UNLOCKED,
        FLP_SECT_ACCESS
    } flp_state_t;

endpackage

// [src/flp_ctrl.sv]
/*
 * Flash lock and sector protect controller. Gates byte program, page
 * erase and mass erase requests toward the flash array.
 * Assumes register writes and the program strobe arrive from logic on
 * clk; the option bit and debug request are static straps or slow pins.
 */
`timescale 1ns/1ps
// What this block does
// - Option bit zero blocks user program and erase
// - Option bit one enables program and erase
// - Reset always leaves controller locked
// - Page mismatch locks; match activates page
// - 95H erases page if sector unprotected
// - Unexpected control value relocks controller
// - Mass erase only through debug port
// - Unlocked page accepts repeated byte writes
// - Later control write relocks active page
// - Eight protect bits; a sector spans one 512-byte page, so only two sectors exist
// - Protected sector refuses; bits only set
// - Reset clears sector protect register
// - Protect and page select share address
module flp_ctrl
    import flp_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic flash_write_protect_option,
    input wire logic ctl_wr,
    input wire logic [7:0] ctl_wdata,
    input wire logic psel_wr,
    input wire logic [7:0] psel_wdata,
    input wire logic prog_req,
    input wire logic [flp_pkg::FLP_ADDR_W-1:0] prog_addr,
    input wire logic [7:0] prog_data,
    input wire logic dbg_mass_erase_req,
    output logic flash_prog,
    output logic [flp_pkg::FLP_ADDR_W-1:0] flash_addr,
    output logic [7:0] flash_wdata,
    output logic flash_page_erase,
    output logic flash_mass_erase,
    output logic unlocked,
    output logic [7:0] sect_prot,
    output logic [7:0] page_sel
);
    import flp_pkg::*;

    typedef struct packed {
        flp_state_t st;
        logic [7:0] first_page;
        logic [7:0] page_sel;
        logic [7:0] sect_prot;
        logic prog;
        logic [FLP_ADDR_W-1:0] addr;
        logic [7:0] wdata;
        logic perase;
        logic merase;
        logic unl;
    } flp_regs_t;

    flp_regs_t r_q, r_d;
    logic [1:0] rst_sync_q;
    logic rst_n_int;
    logic [1:0] wp_sync_q;
    logic [1:0] dbg_sync_q;
    logic dbg_prev_q;

    // Sector of a byte address: an eighth of flash, but never below a page,
    // so with large pages a sector and a page are the same span
    function automatic logic [FLP_SECT_ADDR_W-1:0] addr_sector(
        input logic [FLP_ADDR_W-1:0] a);
        logic [FLP_ADDR_W-1:0] s;
        s = a >> FLP_SECT_SHIFT;
        addr_sector = s[FLP_SECT_ADDR_W-1:0];
    endfunction

    // Sector number of a page
    function automatic logic [FLP_SECT_ADDR_W-1:0] page_sector(
        input logic [7:0] pg);
        logic [FLP_ADDR_W-1:0] a;
        a = {pg[FLP_PAGE_W-1:0], {FLP_PAGE_BITS{1'b0}}};
        page_sector = addr_sector(a);
    endfunction

    function automatic logic sect_is_prot(input logic [7:0] prot,
        input logic [FLP_SECT_ADDR_W-1:0] s);
        sect_is_prot = prot[s];
    endfunction

    // Reset release synchroniser
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n_int = rst_sync_q[1];

    // Option bit and debug request come from outside the clock domain
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            wp_sync_q <= 2'h0;
            dbg_sync_q <= 2'h0;
            dbg_prev_q <= 1'b0;
        end
        else
        begin
            wp_sync_q <= {wp_sync_q[0], flash_write_protect_option};
            dbg_sync_q <= {dbg_sync_q[0], dbg_mass_erase_req};
            dbg_prev_q <= dbg_sync_q[1];
        end
    end

    // Lock sequencer and command gating
    always_comb
    begin
        logic wr_ok;
        logic [FLP_SECT_ADDR_W-1:0] psec;
        logic [7:0] addr_page;
        wr_ok = wp_sync_q[1];
        psec = page_sector(r_q.page_sel);
        addr_page = 8'h00;
        addr_page[FLP_PAGE_W-1:0] = prog_addr[FLP_ADDR_W-1 -: FLP_PAGE_W];
        r_d = r_q;
        r_d.prog = 1'b0;
        r_d.perase = 1'b0;
        // Mass erase only from the debug port, even when write protected
        r_d.merase = dbg_sync_q[1] && !dbg_prev_q;
        unique case (r_q.st)
            FLP_LOCKED:
            begin
                if (ctl_wr && ctl_wdata == FLP_KEY1)
                    r_d.st = FLP_KEY1_SEEN;
                else if (ctl_wr && ctl_wdata == FLP_CMD_SECT_SEL)
                    r_d.st = FLP_SECT_ACCESS;
                if (psel_wr)
                begin
                    r_d.page_sel = psel_wdata;
                    r_d.first_page = psel_wdata;
                end
            end
            FLP_KEY1_SEEN:
            begin
                if (ctl_wr)
                    r_d.st = (ctl_wdata == FLP_KEY2) ? FLP_KEY2_SEEN :
                             FLP_LOCKED;
                else if (psel_wr)
                    r_d.st = FLP_LOCKED;
            end
            FLP_KEY2_SEEN:
            begin
                if (ctl_wr)
                    r_d.st = FLP_LOCKED;
                else if (psel_wr)
                begin
                    r_d.page_sel = psel_wdata;
                    r_d.st = (psel_wdata == r_q.first_page) ?
                             FLP_UNLOCKED : FLP_LOCKED;
                end
            end
            FLP_UNLOCKED:
            begin
                if (ctl_wr)
                begin
                    r_d.st = FLP_LOCKED;
                    r_d.perase = (ctl_wdata == FLP_CMD_PAGE_ERASE) && wr_ok
                                 && !sect_is_prot(r_q.sect_prot, psec);
                end
                else if (prog_req && addr_page == r_q.page_sel)
                begin
                    // Page stays open so further bytes may follow
                    r_d.prog = wr_ok && !sect_is_prot(r_q.sect_prot,
                        addr_sector(prog_addr));
                    r_d.addr = prog_addr;
                    r_d.wdata = prog_data;
                end
            end
            FLP_SECT_ACCESS:
            begin
                // Shared address now reaches sector protect; OR only sets
                if (psel_wr)
                begin
                    r_d.sect_prot = r_q.sect_prot | psel_wdata;
                    r_d.st = FLP_LOCKED;
                end
                else if (ctl_wr)
                    r_d.st = FLP_LOCKED;
            end
            default:
                r_d.st = FLP_LOCKED;
        endcase
        r_d.unl = (r_d.st == FLP_UNLOCKED);
    end

    // State register; reset relocks and clears protection
    always_ff @(posedge clk or negedge rst_n_int)
    begin
        if (!rst_n_int)
        begin
            r_q <= '0;
            r_q.st <= FLP_LOCKED;
            r_q.sect_prot <= FLP_SECT_PROT_RST;
            r_q.page_sel <= FLP_PAGE_SEL_RST;
        end
        else
            r_q <= r_d;
    end

    assign flash_prog = r_q.prog;
    assign flash_addr = r_q.addr;
    assign flash_wdata = r_q.wdata;
    assign flash_page_erase = r_q.perase;
    assign flash_mass_erase = r_q.merase;
    assign unlocked = r_q.unl;
    assign sect_prot = r_q.sect_prot;
    assign page_sel = r_q.page_sel;

    // Assertions
    property p_locked_after_reset;
        @(posedge clk) $rose(rst_n_int) |-> !unlocked;
    endproperty
    a_locked_after_reset: assert property (p_locked_after_reset)
        else $error("controller not locked after reset");

    property p_no_user_write_when_wp;
        @(posedge clk) disable iff (!rst_n_int)
        !wp_sync_q[1] |=> !flash_prog && !flash_page_erase;
    endproperty
    a_no_user_write_when_wp: assert property (p_no_user_write_when_wp)
        else $error("program or erase while write protected");

    property p_prot_sticky;
        @(posedge clk) disable iff (!rst_n_int)
        1'b1 |=> ((sect_prot & $past(sect_prot)) == $past(sect_prot));
    endproperty
    a_prot_sticky: assert property (p_prot_sticky)
        else $error("sector protect bit cleared");

    property p_ctl_relocks;
        @(posedge clk) disable iff (!rst_n_int)
        (unlocked && ctl_wr) |=> !unlocked;
    endproperty
    a_ctl_relocks: assert property (p_ctl_relocks)
        else $error("control write did not relock");

    sequence s_key_pair;
        ctl_wr && ctl_wdata == FLP_KEY1 && r_q.st == FLP_LOCKED
        ##1 ctl_wr && ctl_wdata == FLP_KEY2;
    endsequence
    property p_mismatch_locks;
        @(posedge clk) disable iff (!rst_n_int)
        s_key_pair ##1 (psel_wr && psel_wdata != r_q.first_page)
        |=> !unlocked;
    endproperty
    a_mismatch_locks: assert property (p_mismatch_locks)
        else $error("page mismatch did not lock");

    property p_match_unlocks;
        @(posedge clk) disable iff (!rst_n_int)
        s_key_pair ##1 (psel_wr && !ctl_wr && psel_wdata == r_q.first_page)
        |=> unlocked;
    endproperty
    a_match_unlocks: assert property (p_match_unlocks)
        else $error("page match did not unlock");

    property p_erase_needs_unprot;
        @(posedge clk) disable iff (!rst_n_int)
        flash_page_erase |-> !r_q.sect_prot[page_sector(r_q.page_sel)]
                             && $past(unlocked);
    endproperty
    a_erase_needs_unprot: assert property (p_erase_needs_unprot)
        else $error("erase on protected or locked page");

    property p_prog_keeps_unlock;
        @(posedge clk) disable iff (!rst_n_int)
        flash_prog |-> unlocked;
    endproperty
    a_prog_keeps_unlock: assert property (p_prog_keeps_unlock)
        else $error("page relocked after byte write");

    property p_prog_unprot;
        @(posedge clk) disable iff (!rst_n_int)
        flash_prog |-> !sect_prot[addr_sector(flash_addr)];
    endproperty
    a_prog_unprot: assert property (p_prog_unprot)
        else $error("program into protected sector");

    property p_mass_from_dbg;
        @(posedge clk) disable iff (!rst_n_int)
        flash_mass_erase |-> $past(dbg_sync_q[1]);
    endproperty
    a_mass_from_dbg: assert property (p_mass_from_dbg)
        else $error("mass erase without debug request");

endmodule

// [verification/flp_flash_model.sv]
/*
 Flash array model: stores programmed bytes, erases a page or all.
 Assumes the controller's one-cycle strobes, sampled on clk.
*/
`timescale 1ns/1ps
module flp_flash_model
    import flp_pkg::*;
(
    input wire logic clk,
    input wire logic flash_prog,
    input wire logic [flp_pkg::FLP_ADDR_W-1:0] flash_addr,
    input wire logic [7:0] flash_wdata,
    input wire logic flash_page_erase,
    input wire logic flash_mass_erase,
    input wire logic [7:0] page_sel
);
    logic [7:0] mem [0:(1<<FLP_ADDR_W)-1];
    int n_mass;
    // Erased cells read all ones, so the array starts that way
    initial
    begin
        foreach (mem[i]) mem[i] = 8'hFF;
        n_mass = 0;
    end
    // One action per strobe; the page is the top address bit
    always @(posedge clk)
    begin
        if (flash_prog)
            mem[flash_addr] <= flash_wdata;
        if (flash_page_erase)
            for (int i = 0; i < (1<<FLP_PAGE_BITS); i++)
                mem[{page_sel[FLP_PAGE_W-1:0], i[FLP_PAGE_BITS-1:0]}] <= 8'hFF;
        if (flash_mass_erase)
        begin
            foreach (mem[i]) mem[i] <= 8'hFF;
            n_mass <= n_mass + 1;
        end
    end
endmodule

// [verification/test_flash_lock_and_sector_protect.sv]
/*
 Self-checking bench for the flash lock and sector protect block.
 Assumes requests one per cycle, driven 2 ns after the rising edge.
*/
`timescale 1ns/1ps
module test_flash_lock_and_sector_protect;
    import flp_pkg::*;
    logic clk = 0, rst_b = 0, flash_write_protect_option = 1;
    logic ctl_wr = 0, psel_wr = 0, prog_req = 0, dbg_mass_erase_req = 0;
    logic [7:0] ctl_wdata = 0, psel_wdata = 0, prog_data = 0;
    logic [9:0] prog_addr = 0;
    logic flash_prog, flash_page_erase, flash_mass_erase, unlocked;
    logic [9:0] flash_addr;
    logic [7:0] flash_wdata, sect_prot, page_sel;
    int n_errors = 0, checked = 0, cycles = 0;

    flp_ctrl i_dut (.clk(clk), .rst_b(rst_b),
        .flash_write_protect_option(flash_write_protect_option),
        .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .psel_wr(psel_wr),
        .psel_wdata(psel_wdata), .prog_req(prog_req),
        .prog_addr(prog_addr), .prog_data(prog_data),
        .dbg_mass_erase_req(dbg_mass_erase_req), .flash_prog(flash_prog),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_page_erase(flash_page_erase),
        .flash_mass_erase(flash_mass_erase), .unlocked(unlocked),
        .sect_prot(sect_prot), .page_sel(page_sel));
    flp_flash_model i_mem (.clk(clk), .flash_prog(flash_prog),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_page_erase(flash_page_erase),
        .flash_mass_erase(flash_mass_erase), .page_sel(page_sel));

    always #10 clk = ~clk;
    // Hang guard: the whole sequence needs well under 500 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            wrap_up();
        end
    end

    task step;
        @(posedge clk);
        #2;
    endtask
    task chk(input string s, input logic [9:0] e, input logic [9:0] g);
        checked++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            n_errors++;
        end
    endtask
    // Kind 0 control write, 1 page select write, 2 byte program
    task req(input int k, input logic [7:0] v, input logic [9:0] a);
        ctl_wr = (k == 0);
        psel_wr = (k == 1);
        prog_req = (k == 2);
        ctl_wdata = v;
        psel_wdata = v;
        prog_data = v;
        prog_addr = a;
        step();
    endtask
    task idle;
        req(3, 8'h00, 10'h000);
    endtask
    task unlock(input logic [7:0] p);
        req(1, p, 0);
        req(0, FLP_KEY1, 0);
        req(0, FLP_KEY2, 0);
        req(1, p, 0);
    endtask
    task do_reset;
        rst_b = 0;
        repeat (8) step();
        rst_b = 1;
        repeat (4) step();
    endtask

    task t_unlock;
        unlock(8'h01);
        chk("unlocked", 1, unlocked);
        req(2, 8'hA5, 10'h200);
        chk("flash_prog", 1, flash_prog);
        chk("flash_addr", 10'h200, flash_addr);
        chk("flash_wdata", 8'hA5, flash_wdata);
        req(2, 8'h5A, 10'h201);
        chk("flash_prog", 1, flash_prog);
        chk("unlocked", 1, unlocked);
        req(2, 8'h11, 10'h010);
        chk("flash_prog", 0, flash_prog);
        idle();
        chk("mem", 8'h5A, i_mem.mem[10'h201]);
        req(0, FLP_CMD_PAGE_ERASE, 0);
        chk("flash_page_erase", 1, flash_page_erase);
        chk("unlocked", 0, unlocked);
        idle();
        chk("mem", 8'hFF, i_mem.mem[10'h201]);
        $display("test unlock done");
    endtask
    task t_relock;
        req(1, 1, 0);
        req(0, FLP_KEY1, 0);
        req(0, FLP_KEY2, 0);
        req(1, 0, 0);
        chk("unlocked", 0, unlocked);
        req(1, 0, 0);
        req(0, FLP_KEY1, 0);
        req(0, 8'h55, 0);
        req(0, FLP_KEY2, 0);
        req(1, 0, 0);
        chk("unlocked", 0, unlocked);
        unlock(8'h00);
        req(0, 8'h42, 0);
        chk("unlocked", 0, unlocked);
        req(2, 8'h66, 10'h005);
        chk("flash_prog", 0, flash_prog);
        idle();
        $display("test relock done");
    endtask
    task t_sector;
        req(0, FLP_CMD_SECT_SEL, 0);
        req(1, 8'h02, 0);
        idle();
        chk("sect_prot", 8'h02, sect_prot);
        chk("page_sel", 8'h00, page_sel);
        req(0, FLP_CMD_SECT_SEL, 0);
        req(1, 8'h00, 0);
        idle();
        chk("sect_prot", 8'h02, sect_prot);
        unlock(8'h01);
        req(2, 8'h33, 10'h380);
        chk("flash_prog", 0, flash_prog);
        req(2, 8'h33, 10'h200);
        chk("flash_prog", 0, flash_prog);
        req(0, FLP_CMD_PAGE_ERASE, 0);
        chk("flash_page_erase", 0, flash_page_erase);
        unlock(8'h00);
        req(2, 8'h33, 10'h005);
        chk("flash_prog", 1, flash_prog);
        idle();
        $display("test sector done");
    endtask
    task t_option;
        flash_write_protect_option = 0;
        repeat (3) step();
        unlock(8'h00);
        req(2, 8'h77, 10'h005);
        chk("flash_prog", 0, flash_prog);
        req(0, FLP_CMD_PAGE_ERASE, 0);
        chk("flash_page_erase", 0, flash_page_erase);
        idle();
        chk("mem", 8'h33, i_mem.mem[10'h005]);
        dbg_mass_erase_req = 1;
        repeat (5) step();
        chk("n_mass", 1, i_mem.n_mass);
        chk("mem", 8'hFF, i_mem.mem[10'h005]);
        dbg_mass_erase_req = 0;
        flash_write_protect_option = 1;
        repeat (3) step();
        $display("test option done");
    endtask
    task t_reset;
        chk("unlocked", 0, unlocked);
        chk("sect_prot", 0, sect_prot);
        chk("page_sel", 0, page_sel);
        $display("test reset done");
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Main sequence; the second reset lands with a page open
    initial
    begin
        do_reset();
        t_reset();
        t_unlock();
        t_relock();
        t_sector();
        t_option();
        unlock(8'h01);
        idle();
        do_reset();
        t_reset();
        wrap_up();
    end
endmodule
